// ---- reload_timer_device.sv ----
// Device end: 16-bit reload timer/counter with clock output and up/down mode.
// Assumes trigger and clock pins are already synchronous to clock.
//
// Summary of operation
// - Clock out counts at half peripheral clock
// - Overflow in clock out reloads both bytes
// - No interrupt on clock out overflows
// - Clock out is 50% duty, rate set
// - Generated clock drives timer clock pin
// - Software sets enable, reload, count, run
// - Baud and clock out share reload pair
// - Overflow flag only when serial selects clear
// - External flag set on pin trigger event
// - Bit 5 selects receive clock source
// - Bit 4 selects transmit clock source
// - Trigger enable arms falling pin events
// - Run bit starts and stops timer
// - Counter select picks internal or pin
// - Bit 0 selects capture; serial forces reload
// - Mode bit 1 makes pin clock output
// - Mode bit 0 enables up/down counting
// - Control clears at reset; mode low clears
// - Reserved mode bits never set by software
// - Up count overflow flags and reloads
// - Down count at reload flags, loads FFFFh
// - External flag toggles each up/down wrap
`default_nettype none

module reload_timer_device
   import reload_timer_pkg::*;
(
   reload_timer_if.device   bus,
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        timer_clock_pin_in,      // Pin level in
   output var  logic        timer_clock_pin_out,     // Pin drive level
   output var  logic        timer_clock_pin_oe_b,    // Low while driving
   input  wire logic        trigger_direction_pin,   // Trigger / direction
   input  wire logic        serial_mode_13,          // Serial port in mode 1 or 3
   input  wire logic        other_timer_overflow,    // Alternative baud source
   output var  logic        serial_rx_clock,         // Receive clock pulse
   output var  logic        serial_tx_clock,         // Transmit clock pulse
   output var  logic        timer_irq                // Interrupt request level
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0]  control_q;      // Control byte
   logic [1:0]  mode_q;         // Clock out enable, up/down enable
   logic [15:0] reload_q;       // Reload pair
   logic [15:0] count_q;        // Timer bytes
   logic        half_q;         // Divider for half-rate tick
   logic        pin_q;          // Previous clock pin level
   logic        trig_q;         // Previous trigger pin level
   logic        clk_level_q;    // Clock out level

   // ----------------------------------------
   // Decoded controls
   // ----------------------------------------
   logic serial_sel, clock_out, updn, tick, edge_cnt, trig_fall, trig_evt;
   logic up_ovf, down_unf, ovf, wr_ctl;
   logic [15:0] count_d;

   assign serial_sel = control_q[rx_clk_bit] | control_q[tx_clk_bit];
   assign clock_out  = mode_q[clk_oe_bit];
   assign updn       = mode_q[updn_bit] & ~serial_sel & ~clock_out;
   assign edge_cnt   = pin_q & ~timer_clock_pin_in & ~clock_out;
   // Internal half-rate enable or falling pin edge when counting
   assign tick       = control_q[run_bit] &
                       (control_q[cnt_sel_bit] ? edge_cnt : half_q);
   assign trig_fall  = trig_q & ~trigger_direction_pin;
   assign trig_evt   = trig_fall & control_q[trig_en_bit] & ~serial_sel & ~updn;
   assign up_ovf     = tick & (~updn | trigger_direction_pin) & count_q == count_max;
   assign down_unf   = tick & updn & ~trigger_direction_pin & count_q == reload_q;
   assign ovf        = up_ovf | down_unf;
   assign wr_ctl     = bus.sfr_wr && bus.sfr_addr == timer_control_addr;

   // ----------------------------------------
   // Half-rate tick divider and pin edge history
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         half_q <= 1'b0;
         pin_q  <= 1'b1;
         trig_q <= 1'b1;
      end else begin
         half_q <= ~half_q;                // One pulse every tick_divide clocks
         pin_q  <= timer_clock_pin_in;
         trig_q <= trigger_direction_pin;
      end
   end

   // ----------------------------------------
   // Count register: software write, reload, capture source
   // ----------------------------------------
   always_comb begin
      count_d = count_q;
      if (ovf) begin
         if (down_unf) count_d = count_max;
         else count_d = reload_q;
      end else if (tick) begin
         count_d = (updn && !trigger_direction_pin) ? count_q - 16'h0001 : count_q + 16'h0001;
      end
      // Pin reload only in reload mode, blocked by serial select
      if (trig_evt && !control_q[cap_sel_bit]) count_d = reload_q;
      if (bus.sfr_wr && bus.sfr_addr == timer_low_addr)  count_d[7:0]  = bus.sfr_wdata;
      if (bus.sfr_wr && bus.sfr_addr == timer_high_addr) count_d[15:8] = bus.sfr_wdata;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) count_q <= 16'h0000;
      else count_q <= count_d;
   end

   // Reload pair: software write, or capture of count on pin event
   always_ff @(posedge clock) begin
      if (!rst_b) reload_q <= 16'h0000;
      else begin
         if (trig_evt && control_q[cap_sel_bit]) reload_q <= count_q;
         if (bus.sfr_wr && bus.sfr_addr == reload_low_addr)  reload_q[7:0]  <= bus.sfr_wdata;
         if (bus.sfr_wr && bus.sfr_addr == reload_high_addr) reload_q[15:8] <= bus.sfr_wdata;
      end
   end

   // ----------------------------------------
   // Control byte; hardware set wins over software clear
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) control_q <= control_reset;
      else begin
         if (wr_ctl) control_q <= bus.sfr_wdata;
         // Flag only when serial selects are both clear
         if (ovf && !serial_sel) control_q[ovf_bit] <= 1'b1;
         if (trig_evt) control_q[ext_bit] <= 1'b1;
         // Up/down wraps toggle the external flag as bit 16
         if (ovf && updn) control_q[ext_bit] <= (wr_ctl ? bus.sfr_wdata[ext_bit] : control_q[ext_bit]) ^ 1'b1;
      end
   end

   // Mode byte: only the two defined bits are stored
   always_ff @(posedge clock) begin
      if (!rst_b) mode_q <= mode_reset;
      else if (bus.sfr_wr && bus.sfr_addr == timer_mode_control_addr) mode_q <= bus.sfr_wdata[1:0];
   end

   // ----------------------------------------
   // Clock out level toggles on every overflow
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) clk_level_q <= 1'b0;
      else if (!clock_out) clk_level_q <= 1'b0;
      else if (ovf) clk_level_q <= ~clk_level_q;
   end

   // ----------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         timer_clock_pin_out  <= 1'b0;
         timer_clock_pin_oe_b <= 1'b1;
         serial_rx_clock      <= 1'b0;
         serial_tx_clock      <= 1'b0;
         timer_irq            <= 1'b0;
      end else begin
         timer_clock_pin_out  <= clk_level_q;
         timer_clock_pin_oe_b <= ~clock_out;
         // Source choice for serial clocks; shared reload pair couples rates
         serial_rx_clock <= serial_mode_13 & (control_q[rx_clk_bit] ? ovf : other_timer_overflow);
         serial_tx_clock <= serial_mode_13 & (control_q[tx_clk_bit] ? ovf : other_timer_overflow);
         // Clock out raises no request; external flag silent in up/down
         timer_irq <= ~clock_out & (control_q[ovf_bit] | (control_q[ext_bit] & ~mode_q[updn_bit]));
      end
   end

   // ----------------------------------------
   // Register reads, data in the next cycle
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) bus.sfr_rdata <= byte_zero;
      else if (bus.sfr_rd) begin
         case (bus.sfr_addr)
            timer_control_addr:      bus.sfr_rdata <= control_q;
            timer_mode_control_addr: bus.sfr_rdata <= {6'h00, mode_q};  // Reserved read as zero
            reload_low_addr:         bus.sfr_rdata <= reload_q[7:0];
            reload_high_addr:        bus.sfr_rdata <= reload_q[15:8];
            timer_low_addr:          bus.sfr_rdata <= count_q[7:0];
            timer_high_addr:         bus.sfr_rdata <= count_q[15:8];
            default:                 bus.sfr_rdata <= byte_zero;
         endcase
      end
   end
endmodule

`default_nettype wire

// ---- reload_timer_pkg.sv ----
// Package for the reload timer with clock output: register map, field
// positions, reset values and the core-side bus encoding.
// Assumes one 10 MHz clock shared by the timer and its controller.
`default_nettype none

package reload_timer_pkg;

   // ----------------------------------------
   // Register map on the function-register bus
   // ----------------------------------------
   localparam logic [7:0] timer_control_addr      = 8'hc8;  // Control byte
   localparam logic [7:0] timer_mode_control_addr = 8'hc9;  // Mode byte
   localparam logic [7:0] reload_low_addr         = 8'hca;  // Reload low byte
   localparam logic [7:0] reload_high_addr        = 8'hcb;  // Reload high byte
   localparam logic [7:0] timer_low_addr          = 8'hcc;  // Count low byte
   localparam logic [7:0] timer_high_addr         = 8'hcd;  // Count high byte

   // ----------------------------------------
   // Control byte fields
   // ----------------------------------------
   localparam int ovf_bit     = 7;  // Overflow flag
   localparam int ext_bit     = 6;  // External trigger flag
   localparam int rx_clk_bit  = 5;  // Serial receive clock select
   localparam int tx_clk_bit  = 4;  // Serial transmit clock select
   localparam int trig_en_bit = 3;  // External trigger enable
   localparam int run_bit     = 2;  // Timer run
   localparam int cnt_sel_bit = 1;  // Counter select
   localparam int cap_sel_bit = 0;  // Capture or reload select

   // ----------------------------------------
   // Mode byte fields
   // ----------------------------------------
   localparam int clk_oe_bit = 1;  // Clock out enable
   localparam int updn_bit   = 0;  // Up/down enable

   // ----------------------------------------
   // Reset values and fixed counts
   // ----------------------------------------
   localparam logic [7:0]  control_reset = 8'h00;
   localparam logic [1:0]  mode_reset    = 2'h0;
   localparam logic [15:0] count_max     = 16'hffff;
   localparam logic [7:0]  byte_zero     = 8'h00;
   localparam int          tick_divide   = 2;     // Peripheral clock over two

   // ----------------------------------------
   // Controller command and status register offsets
   // ----------------------------------------
   localparam logic [3:0] cmd_addr_reg   = 4'h0;  // Target register address
   localparam logic [3:0] cmd_data_reg   = 4'h1;  // Write data, starts write
   localparam logic [3:0] cmd_read_reg   = 4'h2;  // Any write starts read
   localparam logic [3:0] cmd_result_reg = 4'h3;  // Last read result
   localparam logic [3:0] cmd_status_reg = 4'h4;  // Bit 0 busy

endpackage

`default_nettype wire

// ---- reload_timer_if.sv ----
// Interface joining the timer device with its function-register master.
// Assumes both ends share one clock; all signals are synchronous.
`default_nettype none

interface reload_timer_if;
   logic [7:0] sfr_addr;   // Register address
   logic [7:0] sfr_wdata;  // Write data
   logic       sfr_wr;     // Write strobe, one cycle
   logic       sfr_rd;     // Read strobe, one cycle
   logic [7:0] sfr_rdata;  // Read data, cycle after strobe

   modport device (input sfr_addr, input sfr_wdata, input sfr_wr, input sfr_rd, output sfr_rdata);
   modport master (output sfr_addr, output sfr_wdata, output sfr_wr, output sfr_rd, input sfr_rdata);
endinterface

`default_nettype wire

// ---- reload_timer_master.sv ----
// Core-side end: turns plain register commands into function-register cycles.
// Assumes the device answers reads in the cycle after the strobe.
`default_nettype none

module reload_timer_master
   import reload_timer_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   reload_timer_if.master   bus,
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output var  logic [7:0]  rdata
);
   // ----------------------------------------
   // Command state
   // ----------------------------------------
   logic [7:0] target_q;   // Target register address
   logic [7:0] result_q;   // Last read value
   logic       pend_q;     // Bus read awaiting data
   logic       busy_q;     // Any bus cycle in flight

   // Software never sets reserved mode bits: they are masked here
   // Clock out needs counter select clear; software orders this
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bus.sfr_addr  <= byte_zero;
         bus.sfr_wdata <= byte_zero;
         bus.sfr_wr    <= 1'b0;
         bus.sfr_rd    <= 1'b0;
      end else begin
         bus.sfr_wr <= wr && addr == cmd_data_reg;
         bus.sfr_rd <= wr && addr == cmd_read_reg;
         if (wr && (addr == cmd_data_reg || addr == cmd_read_reg)) begin
            bus.sfr_addr <= target_q;
            // Upper mode bits forced low
            bus.sfr_wdata <= (target_q == timer_mode_control_addr) ? (wdata & 8'h03) : wdata;
         end
      end
   end

   // Target address register
   always_ff @(posedge clock) begin
      if (!rst_b) target_q <= byte_zero;
      else if (wr && addr == cmd_addr_reg) target_q <= wdata;
   end

   // Capture read data one cycle after the bus strobe
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pend_q   <= 1'b0;
         result_q <= byte_zero;
      end else begin
         pend_q <= bus.sfr_rd;
         if (pend_q) result_q <= bus.sfr_rdata;
      end
   end

   assign busy_q = bus.sfr_wr | bus.sfr_rd | pend_q;

   // Software read port, data one cycle after strobe
   always_ff @(posedge clock) begin
      if (!rst_b) rdata <= byte_zero;
      else if (rd) begin
         case (addr)
            cmd_addr_reg:   rdata <= target_q;
            cmd_result_reg: rdata <= result_q;
            cmd_status_reg: rdata <= {7'h00, busy_q};
            default:        rdata <= byte_zero;
         endcase
      end
   end
endmodule

`default_nettype wire

// ---- reload_timer_clock_out_asserts.sv ----
// Concurrent checks on the register interface and the timer's output pins.
// Assumes one clock domain and a synchronous, active-low reset.
`default_nettype none

module reload_timer_clock_out_asserts
   import reload_timer_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst_b,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       timer_clock_pin_out,
   input wire logic       timer_clock_pin_oe_b,
   input wire logic       serial_rx_clock,
   input wire logic       serial_tx_clock,
   input wire logic       timer_irq
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------
   // Clocking and reset
   // ------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // ------------------------------
   // Steps of a mode change
   // ------------------------------
   sequence mode_write_s;   // Mode byte written on the bus
      sfr_wr && sfr_addr == timer_mode_control_addr;
   endsequence
   sequence clk_on_s;       // Write that selects clock output
      mode_write_s ##0 sfr_wdata[clk_oe_bit];
   endsequence
   sequence clk_off_s;      // Write that frees the pin
      mode_write_s ##0 !sfr_wdata[clk_oe_bit];
   endsequence
   sequence driving_s;      // Pin driven long enough for the mask to land
      !timer_clock_pin_oe_b [*3];
   endsequence

   // ------------------------------
   // Assertions
   // ------------------------------
   rst_vals_a: assert property ($rose(rst_b) |-> sfr_rdata == 8'h00 && timer_clock_pin_oe_b
      && !timer_clock_pin_out && !timer_irq) else $error("outputs not at reset values");
   pin_drive_a: assert property (clk_on_s |-> ##[1:3] !timer_clock_pin_oe_b)
      else $error("clock pin not driven after clock output enabled");
   pin_free_a: assert property (clk_off_s |-> ##[1:3] timer_clock_pin_oe_b)
      else $error("clock pin still driven after clock output disabled");
   irq_quiet_a: assert property (driving_s |-> !timer_irq)
      else $error("interrupt raised during clock output");
   half_min_a: assert property ($changed(timer_clock_pin_out) |=> $stable(timer_clock_pin_out))
      else $error("clock pin changed faster than half rate");
   // Read data stand until the next read strobe; a dropped hold corrupts software reads
   rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   // The master must strip reserved mode bits whatever software hands it
   reserved_clear_a: assert property (mode_write_s |-> sfr_wdata[7:2] == 6'h00)
      else $error("reserved mode bits written");
   strobe_excl_a: assert property (!(sfr_wr && sfr_rd))
      else $error("read and write strobes together");
   tx_pulse_a: assert property (serial_tx_clock |=> !serial_tx_clock)
      else $error("transmit clock pulse longer than one cycle");
   rx_pulse_a: assert property (serial_rx_clock |=> !serial_rx_clock)
      else $error("receive clock pulse longer than one cycle");
endmodule

`default_nettype wire

// ---- test_reload_timer_clock_out.sv ----
// Self-checking bench: master and timer device joined by the register interface.
// Assumes one 10 MHz clock and a synchronous active-low reset.
`default_nettype none

module test_reload_timer_clock_out
   import reload_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------
   // Signals
   // ------------------------------
   logic       clock, rst_b;                   // Clock and reset
   logic [3:0] addr;                           // Master command offset
   logic [7:0] wdata, rdata, v;                // Master data, last read
   logic       wr, rd;                         // Master strobes
   logic       pin_out, oe_b, trig, mode13;    // Timer pins
   logic       cpin, oth;                      // Counter pin, other timer overflow
   logic       rxc, txc, irq;                  // Serial clocks, interrupt
   int         bad_count, checks_done;         // Report counters

   reload_timer_if reload_timer_if_i ();
   reload_timer_master reload_timer_master_i (.clock(clock), .rst_b(rst_b), .bus(reload_timer_if_i),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   // Counter pin and other timer's overflow come from the scenarios, idle high and low
   reload_timer_device reload_timer_device_i (.bus(reload_timer_if_i), .clock(clock), .rst_b(rst_b),
      .timer_clock_pin_in(cpin), .timer_clock_pin_out(pin_out), .timer_clock_pin_oe_b(oe_b),
      .trigger_direction_pin(trig), .serial_mode_13(mode13), .other_timer_overflow(oth),
      .serial_rx_clock(rxc), .serial_tx_clock(txc), .timer_irq(irq));
   reload_timer_clock_out_asserts reload_timer_clock_out_asserts_i (.clock(clock), .rst_b(rst_b),
      .sfr_addr(reload_timer_if_i.sfr_addr), .sfr_wdata(reload_timer_if_i.sfr_wdata),
      .sfr_wr(reload_timer_if_i.sfr_wr), .sfr_rd(reload_timer_if_i.sfr_rd),
      .sfr_rdata(reload_timer_if_i.sfr_rdata), .timer_clock_pin_out(pin_out),
      .timer_clock_pin_oe_b(oe_b), .serial_rx_clock(rxc), .serial_tx_clock(txc), .timer_irq(irq));

   // ------------------------------
   // Helpers
   // ------------------------------
   initial begin   // 100 ns clock
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end
      else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic mwr(input logic [3:0] a, input logic [7:0] d);   // One master command
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);   // Device register write
      mwr(cmd_addr_reg, a);
      mwr(cmd_data_reg, d);
      repeat (3) @(posedge clock);
   endtask

   task automatic mrd(input logic [3:0] a);   // Master register read, called at a rising edge
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      v = rdata;
   endtask

   task automatic reg_rd(input logic [7:0] a);   // Result lands three cycles after the start
      mwr(cmd_addr_reg, a);
      mwr(cmd_read_reg, 8'h00);
      repeat (3) @(posedge clock);
      mrd(cmd_result_reg);
   endtask

   task automatic half(output int n);   // Cycles until the pin flips, bounded
      logic p;
      p = pin_out;
      n = 0;
      while (pin_out === p && n < 200) begin
         @(negedge clock);
         n++;
      end
      if (pin_out === p) begin   // Stuck pin: no point waiting for the guard
         bad_count++;
         $display("mismatch at %0t ns: clock pin never toggled", $time);
         end_sim;
      end
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_clkout;   // Reload fffc: four ticks, eight cycles each half
      int         n;
      logic [7:0] a;
      reg_wr(timer_mode_control_addr, 8'h02);
      reg_wr(reload_low_addr, 8'hfc);
      reg_wr(reload_high_addr, 8'hff);
      reg_wr(timer_low_addr, 8'hfc);
      reg_wr(timer_high_addr, 8'hff);
      reg_wr(timer_control_addr, 8'h04);
      chk({7'h00, oe_b}, 8'h00, "pin enable");
      half(n);
      half(n);
      chk(8'(n), 8'h08, "high time");
      half(n);
      chk(8'(n), 8'h08, "low time");
      chk({7'h00, irq}, 8'h00, "interrupt in clock output");
      reg_wr(timer_control_addr, 8'h00);
      reg_rd(timer_high_addr);
      chk(v, 8'hff, "count high after reloads");
      reg_rd(timer_low_addr);
      a = v;
      reg_rd(timer_low_addr);
      chk(v, a, "stopped count");
   endtask

   task automatic t_updn(input logic up, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] want);
      reg_wr(timer_control_addr, 8'h00);
      trig <= up;   // Falling edge here must be ignored with the trigger disarmed
      // Reserved bits set on purpose: the master must strip them
      reg_wr(timer_mode_control_addr, 8'hfd);
      reg_wr(reload_low_addr, 8'h34);
      reg_wr(reload_high_addr, 8'h12);
      reg_wr(timer_low_addr, lo);
      reg_wr(timer_high_addr, hi);
      reg_wr(timer_control_addr, 8'h04);
      reg_rd(timer_control_addr);
      chk(v, 8'hc4, "flags after wrap");
      chk({7'h00, irq}, 8'h01, "interrupt after wrap");
      reg_wr(timer_control_addr, 8'h00);
      chk({7'h00, irq}, 8'h00, "interrupt after clear");
      reg_rd(timer_high_addr);
      chk(v, want, "count high after wrap");
   endtask

   task automatic t_serial(input logic [7:0] ctl, input logic [7:0] nr, input logic [7:0] nt);
      int r;
      int t;
      mode13 <= 1'b1;
      reg_wr(timer_mode_control_addr, 8'h00);
      reg_wr(reload_low_addr, 8'hff);
      reg_wr(reload_high_addr, 8'hff);
      reg_wr(timer_low_addr, 8'hff);
      reg_wr(timer_high_addr, 8'hff);
      reg_wr(timer_control_addr, ctl);
      r = 0;
      t = 0;
      // Overflow every tick gives ten pulses in twenty cycles; the other timer gives five
      for (int k = 0; k < 20; k++) begin
         @(posedge clock);
         oth <= (k % 4 == 1);
         @(negedge clock);
         r += int'(rxc === 1'b1);
         t += int'(txc === 1'b1);
      end
      chk(8'(r), nr, "receive clock pulses");
      chk(8'(t), nt, "transmit clock pulses");
      reg_rd(timer_control_addr);
      chk(v, ctl, "no overflow flag with serial clocks");
      reg_wr(timer_control_addr, 8'h00);
   endtask

   task automatic trig_pulse;   // One falling edge on the trigger pin
      @(posedge clock);
      trig <= 1'b0;
      @(posedge clock);
      trig <= 1'b1;
   endtask

   task automatic t_trig;   // Pin counting, trigger reload, capture, disarmed edge
      trig <= 1'b1;
      reg_wr(reload_low_addr, 8'h5a);
      reg_wr(reload_high_addr, 8'ha5);
      reg_wr(timer_low_addr, 8'h00);
      reg_wr(timer_high_addr, 8'h00);
      reg_wr(timer_control_addr, 8'h06);   // Counter select and run
      repeat (3) begin
         @(posedge clock);
         cpin <= 1'b0;
         @(posedge clock);
         cpin <= 1'b1;
      end
      reg_wr(timer_control_addr, 8'h08);   // Stop, arm trigger in reload mode
      reg_rd(timer_low_addr);
      chk(v, 8'h03, "falling pin edges counted");
      trig_pulse;
      reg_rd(timer_control_addr);
      chk(v, 8'h48, "external flag after reload");
      chk({7'h00, irq}, 8'h01, "interrupt from external flag");
      reg_rd(timer_high_addr);
      chk(v, 8'ha5, "count reloaded by pin");
      reg_wr(timer_control_addr, 8'h09);   // Capture mode, flag cleared
      reg_wr(timer_low_addr, 8'h3c);
      reg_wr(timer_high_addr, 8'hc3);
      trig_pulse;
      reg_rd(timer_control_addr);
      chk(v, 8'h49, "external flag after capture");
      reg_rd(reload_high_addr);
      chk(v, 8'hc3, "count captured into reload pair");
      reg_wr(timer_control_addr, 8'h01);   // Disarmed: edge must be ignored
      trig_pulse;
      reg_rd(timer_control_addr);
      chk(v, 8'h01, "flag set by disarmed edge");
      chk({7'h00, oe_b}, 8'h01, "pin released outside clock output");
   endtask

   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial begin
      bad_count = 0;
      checks_done = 0;
      rst_b = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      trig = 1'b1;
      mode13 = 1'b0;
      cpin = 1'b1;
      oth = 1'b0;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      reg_rd(timer_control_addr);
      chk(v, control_reset, "control at reset");
      reg_rd(timer_mode_control_addr);
      chk(v, 8'h00, "mode at reset");
      reg_rd(8'h80);
      chk(v, 8'h00, "unmapped read");
      // Master status and target readback around one bus read
      mwr(cmd_addr_reg, timer_low_addr);
      mwr(cmd_read_reg, 8'h00);
      mrd(cmd_status_reg);
      chk(v, 8'h01, "busy during bus read");
      repeat (2) @(posedge clock);
      mrd(cmd_status_reg);
      chk(v, 8'h00, "idle after bus read");
      @(posedge clock);
      mrd(cmd_addr_reg);
      chk(v, timer_low_addr, "target readback");
      t_clkout;
      t_updn(1'b1, 8'hfe, 8'hff, 8'h12);
      t_updn(1'b0, 8'h35, 8'h12, 8'hff);
      t_serial(8'h34, 8'h0a, 8'h0a);
      t_serial(8'h14, 8'h05, 8'h0a);
      t_serial(8'h24, 8'h0a, 8'h05);
      t_trig;
      end_sim;
   end

   initial begin   // Hang guard
      repeat (20000) @(posedge clock);
      bad_count++;
      end_sim;
   end
endmodule

`default_nettype wire
